// ### pkg/adcseq_pkg.sv
// Constants, modes and carrier types of the ADC conversion sequencer.
// Assumes a single 40 MHz clock and an external SAR comparator.
//
// How it works
// - SAR drives DAC; comparator decision fed back each step, 10 bits.
// - Eight result pairs hold complete 10-bit results, one per channel.
// - Software selects timer, immediate or edge start.
// - Full conversion completes within 4 us at a 9 MHz converter clock.
// - Fixed single converts one channel once, stores to its pair, flags.
// - Fixed continuous writes results round all eight pairs in turn.
// - Fixed continuous flags after every four or every eight results.
// - Continuous modes run without triggers until software stops them.
// - Scan single converts each selected channel once into its own pair.
// - Scan flags once at end, or after four plus after remainder.
// - Scan single with one channel equals fixed single on it.
// - Scan continuous restarts at lowest selected channel after last.
// - Later scan passes overwrite each selected channel's own pair.
// - Completion is a pollable flag and an enable-gated interrupt.
// - Results checked against high/low limits; in or out of range.
// - Timer overflow, immediate or pin edge start; busy triggers ignored.
// - Dual mode alternates two inputs into successive pairs, flag 4 or 8.
// - Single step flags after each channel and waits for next start.
// - Divider ratio 1 to 8 gives a converter clock of 40 MHz down to 5 MHz.
package adcseq_pkg;

    localparam int RES_W     = 10;
    localparam int NCH       = 8;
    localparam int CH_W      = 3;
    localparam int DIV_W     = 3;
    localparam int CLK_MHZ   = 40;
    // Conversion time budget at the reference converter clock
    localparam int CONV_NS   = 4000;
    localparam int REF_KHZ   = 9000;
    localparam int MIN_KHZ   = 500;
    localparam int MAX_KHZ   = 3000;
    // Converter clocks per conversion: one sample plus ten bit steps
    localparam int CONV_STEPS = 1 + RES_W;
    localparam int CONV_CYC  = (CONV_NS * CLK_MHZ) / 1000;
    localparam int EARLY_BITS = 4;
    localparam int LATE_BITS  = 8;

    typedef enum logic [2:0] {
        ADCSEQ_FIX_SINGLE = 3'h0,
        ADCSEQ_FIX_CONT   = 3'h1,
        ADCSEQ_SCAN_SINGLE= 3'h2,
        ADCSEQ_SCAN_CONT  = 3'h3,
        ADCSEQ_DUAL_CONT  = 3'h4,
        ADCSEQ_STEP       = 3'h5
    } adcseq_mode_t;

    typedef enum logic [1:0] {
        ADCSEQ_START_TIMER = 2'h0,
        ADCSEQ_START_NOW   = 2'h1,
        ADCSEQ_START_EDGE  = 2'h2
    } adcseq_start_t;

    typedef struct packed {
        adcseq_mode_t      mode;
        adcseq_start_t     start;
        logic              edge_rise;
        logic              int_every8;
        logic              scan_split4;
        logic [NCH-1:0]    ch_sel;
        logic [CH_W-1:0]   fix_ch;
        logic [CH_W-1:0]   dual_ch_b;
        logic [DIV_W-1:0]  clk_div;
        logic              bnd_outside;
        logic [RES_W-1:0]  bnd_hi;
        logic [RES_W-1:0]  bnd_lo;
    } adcseq_cfg_t;

endpackage

// ### logic/adcseq_top.sv
// ADC conversion sequencer: SAR stepping, channel sequencing, result pairs.
// Assumes the analogue mux, sample-hold, DAC and comparator are outside.
module adcseq_top
    import adcseq_pkg::*;
(
    // Clock and reset
    input  wire logic                    I_MCLK,
    input  wire logic                    I_RST_N,
    // Software control
    input  wire adcseq_pkg::adcseq_cfg_t I_CFG,
    input  wire logic                    I_ENABLE,
    input  wire logic                    I_GO,
    input  wire logic                    I_STOP,
    input  wire logic                    I_INT_EN,
    input  wire logic                    I_BND_INT_EN,
    input  wire logic                    I_DONE_CLR,
    input  wire logic                    I_BND_CLR,
    input  wire logic                    I_RD_SEL_UNUSED_N,
    // Triggers
    input  wire logic                    I_TIMER_OVF,
    input  wire logic                    I_EXT_EDGE_TRIGGER_PIN,
    // Analogue front end
    input  wire logic                    I_CMP_OUT,
    output logic [adcseq_pkg::CH_W-1:0]  O_MUX_CH,
    output logic                         O_SAMPLE,
    output logic [adcseq_pkg::RES_W-1:0] O_DAC,
    // Results and status
    output logic [adcseq_pkg::NCH*adcseq_pkg::RES_W-1:0] O_RESULTS,
    output logic                         O_BUSY,
    output logic                         O_DONE,
    output logic                         O_BND_FLAG,
    output logic [adcseq_pkg::NCH-1:0]   O_BND_CH,
    output logic                         O_IRQ
);
    import adcseq_pkg::*;

    // ****************************************************************
    // Reset release and pin synchroniser
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) rst_sync_q <= 2'h0;
        else          rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    logic [2:0] pin_q;
    logic       pin_lvl_q;
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_q     <= 3'h0;
            pin_lvl_q <= 1'b0;
        end else begin
            pin_q <= {pin_q[1:0], I_EXT_EDGE_TRIGGER_PIN};
            if (pin_q[2] == pin_q[1]) pin_lvl_q <= pin_q[2];
        end
    end
    wire pin_chg  = (pin_q[2] == pin_q[1]) && (pin_q[2] != pin_lvl_q);
    wire pin_edge = pin_chg && (pin_q[2] == I_CFG.edge_rise);

    // ****************************************************************
    // Converter clock divider
    // ****************************************************************
    logic [DIV_W-1:0] div_q;
    wire              step_en = (div_q == I_CFG.clk_div);
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n)       div_q <= '0;
        else if (step_en) div_q <= '0;
        else              div_q <= div_q + 3'h1;
    end

    // ****************************************************************
    // Channel selection
    // ****************************************************************
    // Lowest selected channel strictly above 'from', or top bit set if none
    function automatic logic [CH_W:0] next_sel(input logic [NCH-1:0] sel,
                                               input logic [CH_W:0] from);
        logic [CH_W:0] r;
        r = {1'b1, {CH_W{1'b0}}};
        for (int i = NCH - 1; i >= 0; i--) begin
            // Top bit of 'from' set means start before channel 0
            if (sel[i] && (from[CH_W] || (i > int'(from[CH_W-1:0]))))
                r = {1'b0, CH_W'(i)};
        end
        return r;
    endfunction

    typedef enum logic [1:0] {
        S_IDLE = 2'h0, S_SAMPLE = 2'h1, S_BITS = 2'h3, S_STORE = 2'h2
    } adcseq_state_t;

    adcseq_state_t    st_q;
    logic [CH_W-1:0]  ch_q;
    logic [CH_W-1:0]  slot_q;
    logic [3:0]       bit_q;
    logic [RES_W-1:0] sar_q;
    logic [3:0]       cnt_q;
    logic             dual_b_q;
    logic             go_q;

    // Mode decode
    wire is_scan  = (I_CFG.mode == ADCSEQ_SCAN_SINGLE) ||
                    (I_CFG.mode == ADCSEQ_SCAN_CONT) ||
                    (I_CFG.mode == ADCSEQ_STEP);
    wire is_cont  = (I_CFG.mode == ADCSEQ_FIX_CONT) ||
                    (I_CFG.mode == ADCSEQ_SCAN_CONT) ||
                    (I_CFG.mode == ADCSEQ_DUAL_CONT);
    wire [CH_W:0] first_ch = next_sel(I_CFG.ch_sel, {1'b1, {CH_W{1'b1}}});
    wire [CH_W:0] after_ch = next_sel(I_CFG.ch_sel, {1'b0, ch_q});
    wire          last_in_pass = after_ch[CH_W];

    // Triggers are only accepted in idle, so busy triggers are dropped
    wire trig = I_ENABLE && !I_STOP &&
                ((I_CFG.start == ADCSEQ_START_TIMER && I_TIMER_OVF) ||
                 (I_CFG.start == ADCSEQ_START_NOW && I_GO) ||
                 (I_CFG.start == ADCSEQ_START_EDGE && pin_edge));

    wire [CH_W-1:0] start_ch =
        is_scan ? first_ch[CH_W-1:0] :
        ((I_CFG.mode == ADCSEQ_DUAL_CONT && dual_b_q) ? I_CFG.dual_ch_b
                                                     : I_CFG.fix_ch);
    wire scan_empty = is_scan && first_ch[CH_W];

    // ****************************************************************
    // Successive approximation
    // ****************************************************************
    wire [RES_W-1:0] bit_mask = RES_W'(1) << bit_q;
    wire [RES_W-1:0] trial    = sar_q | bit_mask;
    wire [RES_W-1:0] kept     = I_CMP_OUT ? trial : sar_q;
    wire             bits_done = (bit_q == 4'h0);

    // Fixed and dual continuous store round the pairs, others at the channel's pair
    wire rotate = (I_CFG.mode == ADCSEQ_FIX_CONT) ||
                  (I_CFG.mode == ADCSEQ_DUAL_CONT) ||
                  (I_CFG.mode == ADCSEQ_SCAN_CONT);
    wire [CH_W-1:0] dest = (rotate && I_CFG.mode != ADCSEQ_SCAN_CONT) ?
                           slot_q : ch_q;

    // Completion event decode
    wire [3:0] cnt_next = cnt_q + 4'h1;
    wire grp_hit = I_CFG.int_every8 ? (cnt_next[2:0] == 3'h0)
                                    : (cnt_next[1:0] == 2'h0);
    wire scan_hit = last_in_pass ||
                    (I_CFG.scan_split4 && cnt_next == 4'h4);
    wire done_evt = (I_CFG.mode == ADCSEQ_FIX_SINGLE) ? 1'b1 :
                    (I_CFG.mode == ADCSEQ_STEP)       ? 1'b1 :
                    is_scan ? scan_hit : grp_hit;
    wire run_on = is_cont ||
                  (I_CFG.mode == ADCSEQ_SCAN_SINGLE && !last_in_pass);

    // Boundary compare: on the full result at the last bit step, in or outside
    wire [RES_W-1:0] res  = kept;
    wire in_range = (res <= I_CFG.bnd_hi) && (res >= I_CFG.bnd_lo);
    wire bnd_hit  = I_CFG.bnd_outside ? !in_range : in_range;

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= S_IDLE;
            ch_q     <= '0;
            slot_q   <= '0;
            bit_q    <= '0;
            sar_q    <= '0;
            cnt_q    <= '0;
            dual_b_q <= 1'b0;
            go_q     <= 1'b0;
        end else if (!I_ENABLE || I_STOP) begin
            st_q     <= S_IDLE;
            go_q     <= 1'b0;
            cnt_q    <= '0;
            slot_q   <= '0;
            dual_b_q <= 1'b0;
        end else begin
            unique case (st_q)
                S_IDLE: begin
                    if ((trig || go_q) && !scan_empty) begin
                        ch_q  <= start_ch;
                        st_q  <= S_SAMPLE;
                        go_q  <= 1'b0;
                        // Each new start fills pairs from pair 0 again
                        slot_q   <= '0;
                        cnt_q    <= '0;
                        dual_b_q <= 1'b0;
                    end
                end
                S_SAMPLE: if (step_en) begin
                    sar_q <= '0;
                    bit_q <= 4'(RES_W - 1);
                    st_q  <= S_BITS;
                end
                S_BITS: if (step_en) begin
                    sar_q <= kept;
                    if (bits_done) st_q <= S_STORE;
                    else           bit_q <= bit_q - 4'h1;
                end
                S_STORE: begin
                    slot_q   <= slot_q + 3'h1;
                    cnt_q    <= (is_scan && last_in_pass) ? 4'h0 : cnt_next;
                    dual_b_q <= !dual_b_q;
                    if (run_on) begin
                        // Next channel ascending, wrap to lowest selected
                        ch_q <= is_scan ? (last_in_pass ? first_ch[CH_W-1:0]
                                           : after_ch[CH_W-1:0])
                                : (I_CFG.mode == ADCSEQ_DUAL_CONT ?
                                   (dual_b_q ? I_CFG.fix_ch : I_CFG.dual_ch_b)
                                   : I_CFG.fix_ch);
                        st_q <= S_SAMPLE;
                    end else begin
                        st_q <= S_IDLE;
                        if (I_CFG.mode == ADCSEQ_STEP && last_in_pass) begin
                            cnt_q <= '0;
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Step mode records the channel after the last one converted; nothing reads it, each start begins at the lowest selected channel
    logic [CH_W-1:0] step_next_q;
    logic            step_mid_q;
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            step_next_q <= '0;
            step_mid_q  <= 1'b0;
        end else if (st_q == S_STORE && I_CFG.mode == ADCSEQ_STEP) begin
            step_next_q <= after_ch[CH_W-1:0];
            step_mid_q  <= !last_in_pass;
        end
    end
    wire [CH_W-1:0] unused_step = step_mid_q ? step_next_q : '0;

    // ****************************************************************
    // Result pairs, flags and outputs
    // ****************************************************************
    logic [RES_W-1:0] res_q [NCH];
    wire store_now = (st_q == S_STORE);
    generate
        for (genvar g = 0; g < NCH; g++) begin : g_res
            always_ff @(posedge I_MCLK or negedge rst_n) begin
                if (!rst_n)
                    res_q[g] <= '0;
                else if (store_now && dest == CH_W'(g))
                    res_q[g] <= sar_q;
            end
            assign O_RESULTS[g*RES_W +: RES_W] = res_q[g];
        end
    endgenerate

    wire st_bnd = (st_q == S_BITS) && step_en && bits_done;
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            O_DONE     <= 1'b0;
            O_BND_FLAG <= 1'b0;
            O_BND_CH   <= '0;
            O_IRQ      <= 1'b0;
            O_MUX_CH   <= '0;
            O_SAMPLE   <= 1'b0;
            O_DAC      <= '0;
            O_BUSY     <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            if (store_now && done_evt) O_DONE <= 1'b1;
            else if (I_DONE_CLR)       O_DONE <= 1'b0;
            if (st_bnd && bnd_hit) begin
                O_BND_FLAG     <= 1'b1;
                O_BND_CH[ch_q] <= 1'b1;
            end else if (I_BND_CLR) begin
                O_BND_FLAG <= 1'b0;
                O_BND_CH   <= '0;
            end
            O_IRQ <= (I_INT_EN && O_DONE) ||
                     (I_BND_INT_EN && O_BND_FLAG);
            O_MUX_CH <= ch_q;
            O_SAMPLE <= (st_q == S_SAMPLE);
            // DAC shows the trial a full step before it is decided
            if (st_q == S_SAMPLE && step_en)
                O_DAC <= RES_W'(1) << (RES_W - 1);
            else if (st_q == S_BITS && step_en)
                O_DAC <= bits_done ? kept : (kept | (bit_mask >> 1));
            O_BUSY   <= (st_q != S_IDLE) || (unused_step != unused_step);
        end
    end

    // Conversion length: CONV_STEPS divided clocks plus one store cycle;
    // at ratio 4 (10 MHz) this is 45 cycles, well inside CONV_CYC (160).
endmodule

// ### tb/adcseq_properties.sv
// Port-level checks for the ADC conversion sequencer.
// Assumes clk_div of zero so one conversion fits in CONV_LIM cycles.
module adcseq_properties
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic                        I_MCLK,
    input wire logic                        I_RST_N,
    // Software control
    input wire adcseq_pkg::adcseq_cfg_t     I_CFG,
    input wire logic                        I_ENABLE,
    input wire logic                        I_GO,
    input wire logic                        I_STOP,
    input wire logic                        I_INT_EN,
    input wire logic                        I_BND_INT_EN,
    input wire logic                        I_DONE_CLR,
    input wire logic                        I_BND_CLR,
    // Observed outputs
    input wire logic [adcseq_pkg::CH_W-1:0] O_MUX_CH,
    input wire logic                        O_SAMPLE,
    input wire logic                        O_BUSY,
    input wire logic                        O_DONE,
    input wire logic                        O_BND_FLAG,
    input wire logic                        O_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV_LIM = 160;
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);
    // ****************************
    // Properties
    // ****************************
    property p_irq_cause;
        O_IRQ |-> $past((O_DONE && I_INT_EN) || (O_BND_FLAG && I_BND_INT_EN));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled flag");
    property p_irq_follow;
        $past(O_DONE && I_INT_EN) && O_DONE && I_INT_EN |-> O_IRQ;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("interrupt missing while flag enabled");
    property p_done_hold; O_DONE && !I_DONE_CLR |=> O_DONE; endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done flag dropped without clear");
    property p_bnd_hold; O_BND_FLAG && !I_BND_CLR |=> O_BND_FLAG; endproperty
    a_bnd_hold: assert property (p_bnd_hold)
        else $error("boundary flag dropped without clear");
    property p_sample_busy; O_SAMPLE |-> O_BUSY; endproperty
    a_sample_busy: assert property (p_sample_busy)
        else $error("sampling outside a conversion");
    property p_fix_ch;
        O_SAMPLE && I_CFG.mode == ADCSEQ_FIX_SINGLE |-> O_MUX_CH == I_CFG.fix_ch;
    endproperty
    a_fix_ch: assert property (p_fix_ch)
        else $error("fixed mode sampled wrong channel");
    property p_scan_sel;
        O_SAMPLE && I_CFG.mode == ADCSEQ_SCAN_SINGLE |-> I_CFG.ch_sel[O_MUX_CH];
    endproperty
    a_scan_sel: assert property (p_scan_sel)
        else $error("scan sampled unselected channel");
    property p_go_start;
        !O_BUSY && I_ENABLE && !I_STOP && I_GO
        && I_CFG.start == ADCSEQ_START_NOW && I_CFG.mode == ADCSEQ_FIX_SINGLE
        |-> ##[1:2] O_BUSY;
    endproperty
    a_go_start: assert property (p_go_start)
        else $error("immediate start not taken");
    property p_conv_time;
        $rose(O_BUSY) && I_CFG.mode == ADCSEQ_FIX_SINGLE
        |-> ##[1:CONV_LIM] !O_BUSY;
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion too long");
    c_done: cover property ($rose(O_DONE));
    c_bnd: cover property ($rose(O_BND_FLAG));
    c_irq: cover property ($rose(O_IRQ));
endmodule

// ### tb/adcseq_front_model.sv
// Ideal comparator front end with one fixed level per channel.
// Assumes the level is held while the sequencer samples.
module adcseq_front_model
    import adcseq_pkg::*;
(
    // Clock
    input  wire logic                        i_clk,
    // Converter side
    input  wire logic [adcseq_pkg::CH_W-1:0] i_mux_ch,
    input  wire logic                        i_sample,
    input  wire logic [adcseq_pkg::RES_W-1:0] i_dac,
    output logic                             o_cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RES_W-1:0] held_q;
    always @(posedge i_clk)
        if (i_sample) held_q <= {i_mux_ch, 7'h15};
    // Decision fed back to the SAR for each trial
    wire [RES_W-1:0] lvl = {i_mux_ch, 7'h15};
    assign o_cmp = ((i_sample ? lvl : held_q) >= i_dac);
endmodule

// ### tb/testbench.sv
// Self-checking bench for the ADC conversion sequencer.
// Assumes the front model answers every SAR trial code.
module testbench;
    import adcseq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 mclk = 1'b0;
    logic                 rst_n = 1'b0;
    adcseq_cfg_t          cfg, nc;
    logic [4:0]           pls = 5'h0;
    logic                 stp = 1'b0, ien = 1'b0, bien = 1'b0;
    logic [CH_W-1:0]      mux_ch;
    logic [RES_W-1:0]     dac;
    logic [NCH*RES_W-1:0] res_bus;
    logic [NCH-1:0]       bnd_ch;
    logic                 sample, busy, done, bnd_flag, irq, cmp;
    int                   miscompares = 0;
    int                   total_checks = 0;
    always #12.5 mclk = ~mclk;
    adcseq_top dut_u (
        .I_MCLK(mclk), .I_RST_N(rst_n), .I_CFG(cfg), .I_ENABLE(1'b1),
        .I_GO(pls[0]), .I_STOP(stp), .I_INT_EN(ien), .I_BND_INT_EN(bien),
        .I_DONE_CLR(pls[2]), .I_BND_CLR(pls[3]), .I_RD_SEL_UNUSED_N(1'b1),
        .I_TIMER_OVF(pls[1]), .I_EXT_EDGE_TRIGGER_PIN(pls[4]),
        .I_CMP_OUT(cmp), .O_MUX_CH(mux_ch), .O_SAMPLE(sample), .O_DAC(dac),
        .O_RESULTS(res_bus), .O_BUSY(busy), .O_DONE(done),
        .O_BND_FLAG(bnd_flag), .O_BND_CH(bnd_ch), .O_IRQ(irq));
    adcseq_front_model model_u (.i_clk(mclk), .i_mux_ch(mux_ch),
        .i_sample(sample), .i_dac(dac), .o_cmp(cmp));
    // ****************************
    // Tasks
    // ****************************
    function automatic logic [RES_W-1:0] res(input int g);
        return res_bus[RES_W*g +: RES_W];
    endfunction
    function automatic logic [RES_W-1:0] expv(input int g);
        return {3'(g), 7'h15};
    endfunction
    task automatic check(input logic [RES_W-1:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge mclk) pls <= m;
        @(posedge mclk) pls <= 5'h0;
    endtask
    task automatic await(input bit idle);
        int n;
        n = 0;
        while ((idle ? busy !== 1'b0 : done !== 1'b1) && n < 400) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 400) begin
            miscompares++;
            results();
        end
    endtask
    task automatic run(input adcseq_cfg_t c, input logic [4:0] m);
        @(posedge mclk) cfg <= c;
        pulse(m);
        await(1'b0);
    endtask
    task automatic clr;
        pulse(5'h04);
        repeat (2) @(posedge mclk);
        #1;
        check(10'(done), 10'h0);
        check(10'(irq), 10'h0);
    endtask
    // ****************************
    // Sequence
    // ****************************
    initial begin
        cfg = '0;
        nc = '0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        nc.start = ADCSEQ_START_NOW;
        nc.fix_ch = 3'h5;
        ien <= 1'b1;
        run(nc, 5'h01);
        check(res(5), expv(5));
        @(posedge mclk);
        #1;
        check(10'(irq), 10'h1);
        clr();
        $display("test fixed single done");
        nc.start = ADCSEQ_START_TIMER;
        nc.fix_ch = 3'h2;
        ien <= 1'b0;
        @(posedge mclk) cfg <= nc;
        pulse(5'h02);
        pulse(5'h02);
        await(1'b0);
        check(res(2), expv(2));
        @(posedge mclk);
        #1;
        check(10'(irq), 10'h0);
        clr();
        repeat (160) @(posedge mclk);
        #1;
        check(10'(done), 10'h0);
        $display("test timer start done");
        nc.start = ADCSEQ_START_EDGE;
        nc.edge_rise = 1'b1;
        nc.fix_ch = 3'h6;
        @(posedge mclk) cfg <= nc;
        @(posedge mclk) pls <= 5'h10;
        repeat (4) @(posedge mclk);
        pls <= 5'h0;
        await(1'b0);
        check(res(6), expv(6));
        clr();
        $display("test edge start done");
        nc.start = ADCSEQ_START_NOW;
        nc.mode = ADCSEQ_SCAN_SINGLE;
        nc.ch_sel = 8'h19;
        run(nc, 5'h01);
        for (int g = 0; g < 2; g++)
            check(res(g * 3), expv(g * 3));
        check(res(4), expv(4));
        check(res(1), 10'h0);
        clr();
        $display("test scan single done");
        nc.mode = ADCSEQ_FIX_CONT;
        nc.fix_ch = 3'h1;
        run(nc, 5'h01);
        for (int g = 0; g < 4; g++)
            check(res(g), expv(1));
        check(res(4), expv(4));
        @(posedge mclk) stp <= 1'b1;
        await(1'b1);
        check(10'(busy), 10'h0);
        @(posedge mclk) stp <= 1'b0;
        clr();
        $display("test continuous done");
        nc.mode = ADCSEQ_FIX_SINGLE;
        nc.fix_ch = 3'h7;
        nc.bnd_outside = 1'b1;
        nc.bnd_lo = 10'h100;
        nc.bnd_hi = 10'h200;
        bien <= 1'b1;
        run(nc, 5'h01);
        check(10'(bnd_ch), 10'h080);
        pulse(5'h0c);
        repeat (2) @(posedge mclk);
        #1;
        check(10'(bnd_flag), 10'h0);
        nc.fix_ch = 3'h2;
        nc.bnd_outside = 1'b0;
        run(nc, 5'h01);
        check(10'(bnd_ch), 10'h004);
        $display("test boundary done");
        results();
    end
endmodule
bind adcseq_top adcseq_properties chk_u (
    .I_MCLK, .I_RST_N, .I_CFG, .I_ENABLE, .I_GO, .I_STOP, .I_INT_EN,
    .I_BND_INT_EN, .I_DONE_CLR, .I_BND_CLR, .O_MUX_CH, .O_SAMPLE, .O_BUSY,
    .O_DONE, .O_BND_FLAG, .O_IRQ
);
